/* inc/smcr_map.svh */
// Overview of operation
// - register shift amount uses bits 7:0 only
// - immediate shift lengths cover documented per-op ranges
// - rotate-through-carry moves operand right one bit
// - shifts write destination only, source unchanged
// - shift flags: N Z result, C last out
// - leading zeros: 32 for zero, flags untouched
// - compare subtracts, sets flags, discards difference
// - compare-negative adds, sets flags, no destination
// - compares always update N, Z, C, V
// - move copies operand or zero-extended wide immediate
// - copy-inverted writes bitwise NOT of operand
// - move flags: N Z result, C shifter, V kept
// - move with register shift equals shift op
// - move to PC branches with bit0 cleared
// - load top half keeps low half, flags
// - word byte swap reverses all four bytes
// - halves byte swap swaps bytes per halfword
// - signed half swap sign-extends swapped low halfword
// - bit mirror: result bit i is 31-i
// - swap and mirror ops never touch flags
`ifndef SMCR_MAP_SVH
`define SMCR_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SMCR_ADDR_CTRL    8'h00
`define SMCR_ADDR_FIRST   8'h04
`define SMCR_ADDR_SOURCE  8'h08
`define SMCR_ADDR_SHAMT   8'h0c
`define SMCR_ADDR_WIDE    8'h10
`define SMCR_ADDR_DEST    8'h14
`define SMCR_ADDR_FLAGS   8'h18
`define SMCR_ADDR_EXEC    8'h1c
`define SMCR_ADDR_STATUS  8'h20
`define SMCR_ADDR_BRANCH  8'h24

// ----------------------------------------------------------------
// control fields and flag positions
// ----------------------------------------------------------------
`define SMCR_CTL_OP_LSB   0
`define SMCR_CTL_KIND_LSB 4
`define SMCR_CTL_USEIMM   6
`define SMCR_CTL_SETFLG   7
`define SMCR_CTL_TOPC     8
`define SMCR_CTL_IMM_LSB  16
`define SMCR_FLAG_N       3
`define SMCR_FLAG_Z       2
`define SMCR_FLAG_C       1
`define SMCR_FLAG_V       0
`define SMCR_RST_WORD     32'h0000_0000
`define SMCR_RST_FLAGS    4'h0
`define SMCR_LZC_ALLZERO  6'h20

`endif

/* inc/smcr_pkg.sv */
package smcr_pkg;

  typedef enum logic [3:0] {
    OP_SHIFT_LEFT_LOGICAL,
    OP_SHIFT_RIGHT_LOGICAL,
    OP_SHIFT_RIGHT_ARITHMETIC,
    OP_ROTATE_RIGHT,
    OP_ROTATE_THROUGH_CARRY,
    OP_LEADING_ZERO_COUNT,
    OP_COMPARE,
    OP_COMPARE_NEGATIVE,
    OP_MOVE,
    OP_COPY_INVERTED,
    OP_MOVE_WIDE,
    OP_LOAD_TOP_HALF,
    OP_BYTE_SWAP_WORD,
    OP_BYTE_SWAP_HALVES,
    OP_BYTE_SWAP_SIGNED_HALF,
    OP_BIT_MIRROR
  } smcr_op_t;

  typedef enum logic [2:0] {
    SH_LEFT,
    SH_RIGHT,
    SH_ARITH,
    SH_ROTATE,
    SH_EXTEND
  } smcr_shift_t;

endpackage

/* rtl/smcr_shifter.sv */
`timescale 1ns/10ps
module smcr_shifter
  import smcr_pkg::*;
(
  input  wire logic [31:0] valueIn,
  input  wire smcr_shift_t kind,
  input  wire logic [7:0]  amount,
  input  wire logic        carryIn,
  output logic      [31:0] valueOut,
  output logic             carryOut
);

  always_comb
  begin
    logic [32:0] ext;
    logic [63:0] dbl;
    logic [4:0]  low;
    ext      = '0;
    dbl      = '0;
    low      = amount[4:0];
    valueOut = valueIn;
    carryOut = carryIn;
    unique case (kind)
      SH_LEFT:
        if (amount != 8'h00)
        begin
          if (amount < 8'h20)
          begin
            ext      = {1'b0, valueIn} << low;
            valueOut = ext[31:0];
            carryOut = ext[32];
          end
          else
          begin
            valueOut = '0;
            carryOut = (amount == 8'h20) & valueIn[0];
          end
        end
      SH_RIGHT, SH_ARITH:
        if (amount != 8'h00)
        begin
          if (amount < 8'h20)
          begin
            // kept apart so the sign fill never meets an unsigned context
            if (kind == SH_ARITH)
            begin
              ext = 33'($signed({valueIn, 1'b0}) >>> low);
            end
            else
            begin
              ext = {valueIn, 1'b0} >> low;
            end
            valueOut = ext[32:1];
            carryOut = ext[0];
          end
          else
          begin
            valueOut = (kind == SH_ARITH) ? {32{valueIn[31]}} : 32'h0000_0000;
            carryOut = ((kind == SH_ARITH) | (amount == 8'h20)) & valueIn[31];
          end
        end
      SH_ROTATE:
        if (amount != 8'h00)
        begin
          dbl      = {valueIn, valueIn} >> low;
          valueOut = dbl[31:0];
          carryOut = dbl[31];
        end
      SH_EXTEND:
      begin
        valueOut = {carryIn, valueIn[31:1]};
        carryOut = valueIn[0];
      end
      default:
      begin
        valueOut = valueIn;
        carryOut = carryIn;
      end
    endcase
  end

endmodule // smcr_shifter

/* rtl/smcr_revclz.sv */
`timescale 1ns/10ps
`include "smcr_map.svh"
module smcr_revclz
  import smcr_pkg::*;
(
  input  wire logic [31:0] valueIn,
  input  wire smcr_op_t    op,
  output logic      [31:0] valueOut
);

  function automatic logic [5:0] leadZeros(input logic [31:0] v);
    logic [5:0] n;
    logic       found;
    n     = `SMCR_LZC_ALLZERO;
    found = 1'b0;
    for (int i = 31; i >= 0; i--)
    begin
      if (!found && v[i])
      begin
        n     = 6'(31 - i);
        found = 1'b1;
      end
    end
    return n;
  endfunction

  logic [31:0] mirrored;

  for (genvar i = 0; i < 32; i++)
  begin : g_mirror
    assign mirrored[i] = valueIn[31-i];
  end

  always_comb
  begin
    unique case (op)
      OP_BYTE_SWAP_WORD:
        valueOut = {valueIn[7:0], valueIn[15:8], valueIn[23:16], valueIn[31:24]};
      OP_BYTE_SWAP_HALVES:
        valueOut = {valueIn[23:16], valueIn[31:24], valueIn[7:0], valueIn[15:8]};
      OP_BYTE_SWAP_SIGNED_HALF:
        valueOut = {{16{valueIn[7]}}, valueIn[7:0], valueIn[15:8]};
      OP_BIT_MIRROR:
        valueOut = mirrored;
      default:
        valueOut = {26'h0, leadZeros(valueIn)};
    endcase
  end

endmodule // smcr_revclz

/* rtl/smcr_alu.sv */
`timescale 1ns/10ps
`include "smcr_map.svh"
module smcr_alu
  import smcr_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        clkEn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [31:0] destValue,
  output logic      [3:0]  flagsNzcv,
  output logic      [31:0] branchTarget,
  output logic             branchStrobe,
  output logic             execDone
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [31:0] ctrlQ;
  logic [31:0] firstOperandRegQ;
  logic [31:0] sourceValueRegQ;
  logic [31:0] shiftAmountRegQ;
  logic [15:0] wideImmediateQ;
  logic [31:0] destQ;
  logic [3:0]  flagsQ;
  logic [2:0]  statusQ;
  logic [31:0] branchTargetQ;
  logic        branchStrobeQ;
  logic        execDoneQ;
  logic [31:0] prdataQ;
  logic        preadyQ;
  logic        pslverrQ;

  function automatic logic isMapped(input logic [7:0] a);
    return (a == `SMCR_ADDR_CTRL)   || (a == `SMCR_ADDR_FIRST)  ||
           (a == `SMCR_ADDR_SOURCE) || (a == `SMCR_ADDR_SHAMT)  ||
           (a == `SMCR_ADDR_WIDE)   || (a == `SMCR_ADDR_DEST)   ||
           (a == `SMCR_ADDR_FLAGS)  || (a == `SMCR_ADDR_EXEC)   ||
           (a == `SMCR_ADDR_STATUS) || (a == `SMCR_ADDR_BRANCH);
  endfunction

  function automatic logic [1:0] signZero(input logic [31:0] v);
    return {v[31], (v == 32'h0000_0000)};
  endfunction

  // ----------------------------------------------------------------
  // apb slave: one wait state, answer on second access cycle
  // ----------------------------------------------------------------
  logic        accessPh;
  logic        wrEn;
  logic        execStrobe;
  logic [31:0] readData;

  assign accessPh   = psel & penable;
  assign wrEn       = clkEn & accessPh & preadyQ & pwrite;
  assign execStrobe = wrEn & (paddr == `SMCR_ADDR_EXEC);

  always_comb
  begin
    unique case (paddr)
      `SMCR_ADDR_CTRL:   readData = ctrlQ;
      `SMCR_ADDR_FIRST:  readData = firstOperandRegQ;
      `SMCR_ADDR_SOURCE: readData = sourceValueRegQ;
      `SMCR_ADDR_SHAMT:  readData = shiftAmountRegQ;
      `SMCR_ADDR_WIDE:   readData = {16'h0000, wideImmediateQ};
      `SMCR_ADDR_DEST:   readData = destQ;
      `SMCR_ADDR_FLAGS:  readData = {28'h0, flagsQ};
      `SMCR_ADDR_STATUS: readData = {29'h0, statusQ};
      `SMCR_ADDR_BRANCH: readData = branchTargetQ;
      default:           readData = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      preadyQ  <= 1'b0;
      prdataQ  <= `SMCR_RST_WORD;
      pslverrQ <= 1'b0;
    end
    else if (clkEn)
    begin
      preadyQ <= accessPh & ~preadyQ;
      if (accessPh & ~preadyQ)
      begin
        prdataQ  <= pwrite ? 32'h0000_0000 : readData;
        pslverrQ <= ~isMapped(paddr);
      end
    end
  end

  // ----------------------------------------------------------------
  // execution datapath
  // ----------------------------------------------------------------
  smcr_op_t    op;
  smcr_shift_t kind;
  logic [7:0]  amount;
  logic [31:0] shOut;
  logic        shCarry;
  logic [31:0] revOut;
  logic        setFlags;
  logic        toPc;

  assign op       = smcr_op_t'(ctrlQ[`SMCR_CTL_OP_LSB +: 4]);
  assign setFlags = ctrlQ[`SMCR_CTL_SETFLG];
  assign toPc     = ctrlQ[`SMCR_CTL_TOPC];
  // immediate field spans the full documented ranges, register uses one byte
  assign amount   = ctrlQ[`SMCR_CTL_USEIMM] ? {2'b00, ctrlQ[`SMCR_CTL_IMM_LSB +: 6]}
                                            : shiftAmountRegQ[7:0];

  always_comb
  begin
    unique case (op)
      OP_SHIFT_LEFT_LOGICAL:     kind = SH_LEFT;
      OP_SHIFT_RIGHT_LOGICAL:    kind = SH_RIGHT;
      OP_SHIFT_RIGHT_ARITHMETIC: kind = SH_ARITH;
      OP_ROTATE_RIGHT:           kind = SH_ROTATE;
      OP_ROTATE_THROUGH_CARRY:   kind = SH_EXTEND;
      default:  kind = smcr_shift_t'({1'b0, ctrlQ[`SMCR_CTL_KIND_LSB +: 2]});
    endcase
  end

  smcr_shifter u_shifter (
    .valueIn  (sourceValueRegQ),
    .kind     (kind),
    .amount   (amount),
    .carryIn  (flagsQ[`SMCR_FLAG_C]),
    .valueOut (shOut),
    .carryOut (shCarry)
  );

  smcr_revclz u_revclz (
    .valueIn  (sourceValueRegQ),
    .op       (op),
    .valueOut (revOut)
  );

  logic [31:0] resD;
  logic        wrDestD;
  logic [3:0]  flagsD;
  logic        branchD;
  logic [32:0] sum;

  always_comb
  begin
    resD    = shOut;
    wrDestD = 1'b1;
    flagsD  = flagsQ;
    branchD = 1'b0;
    sum     = '0;
    unique case (op)
      OP_SHIFT_LEFT_LOGICAL, OP_SHIFT_RIGHT_LOGICAL, OP_SHIFT_RIGHT_ARITHMETIC,
      OP_ROTATE_RIGHT, OP_ROTATE_THROUGH_CARRY:
        if (setFlags)
        begin
          flagsD[3:2]          = signZero(shOut);
          flagsD[`SMCR_FLAG_C] = shCarry;
        end
      OP_MOVE, OP_COPY_INVERTED:
      begin
        resD = (op == OP_COPY_INVERTED) ? ~shOut : shOut;
        if (toPc && op == OP_MOVE)
        begin
          wrDestD = 1'b0;
          branchD = 1'b1;
        end
        else if (setFlags)
        begin
          flagsD[3:2]          = signZero(resD);
          flagsD[`SMCR_FLAG_C] = shCarry;
        end
      end
      OP_COMPARE:
      begin
        sum     = {1'b0, firstOperandRegQ} + {1'b0, ~shOut} + 33'h1;
        wrDestD = 1'b0;
        resD    = sum[31:0];
        flagsD  = {signZero(resD), sum[32],
                   (firstOperandRegQ[31] != shOut[31]) &&
                   (resD[31] != firstOperandRegQ[31])};
      end
      OP_COMPARE_NEGATIVE:
      begin
        sum     = {1'b0, firstOperandRegQ} + {1'b0, shOut};
        wrDestD = 1'b0;
        resD    = sum[31:0];
        flagsD  = {signZero(resD), sum[32],
                   (firstOperandRegQ[31] == shOut[31]) &&
                   (resD[31] != firstOperandRegQ[31])};
      end
      OP_MOVE_WIDE:
        resD = {16'h0000, wideImmediateQ};
      OP_LOAD_TOP_HALF:
        resD = {wideImmediateQ, destQ[15:0]};
      OP_LEADING_ZERO_COUNT, OP_BYTE_SWAP_WORD, OP_BYTE_SWAP_HALVES,
      OP_BYTE_SWAP_SIGNED_HALF, OP_BIT_MIRROR:
        resD = revOut;
    endcase
  end

  // ----------------------------------------------------------------
  // software registers and operand latches
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrlQ            <= `SMCR_RST_WORD;
      firstOperandRegQ <= `SMCR_RST_WORD;
      sourceValueRegQ  <= `SMCR_RST_WORD;
      shiftAmountRegQ  <= `SMCR_RST_WORD;
      wideImmediateQ   <= 16'h0000;
    end
    else if (wrEn)
    begin
      // the source latch is never written by execution
      unique case (paddr)
        `SMCR_ADDR_CTRL:   ctrlQ            <= pwdata;
        `SMCR_ADDR_FIRST:  firstOperandRegQ <= pwdata;
        `SMCR_ADDR_SOURCE: sourceValueRegQ  <= pwdata;
        `SMCR_ADDR_SHAMT:  shiftAmountRegQ  <= pwdata;
        `SMCR_ADDR_WIDE:   wideImmediateQ   <= pwdata[15:0];
        default:           ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // destination, flags and branch results
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      destQ <= `SMCR_RST_WORD;
    end
    else if (execStrobe && wrDestD)
    begin
      destQ <= resD;
    end
    else if (wrEn && paddr == `SMCR_ADDR_DEST)
    begin
      destQ <= pwdata;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      flagsQ <= `SMCR_RST_FLAGS;
    end
    else if (execStrobe)
    begin
      flagsQ <= flagsD;
    end
    else if (wrEn && paddr == `SMCR_ADDR_FLAGS)
    begin
      flagsQ <= pwdata[3:0];
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      branchTargetQ <= `SMCR_RST_WORD;
      branchStrobeQ <= 1'b0;
      execDoneQ     <= 1'b0;
      statusQ       <= 3'h0;
    end
    else if (clkEn)
    begin
      branchStrobeQ <= execStrobe & branchD;
      execDoneQ     <= execStrobe;
      if (execStrobe)
      begin
        statusQ <= {flagsD != flagsQ, branchD, wrDestD};
        if (branchD)
        begin
          branchTargetQ <= {resD[31:1], 1'b0};
        end
      end
    end
  end

  assign prdata       = prdataQ;
  assign pready       = preadyQ;
  assign pslverr      = pslverrQ;
  assign destValue    = destQ;
  assign flagsNzcv    = flagsQ;
  assign branchTarget = branchTargetQ;
  assign branchStrobe = branchStrobeQ;
  assign execDone     = execDoneQ;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_clz_zero_count: assert property (execStrobe && op == OP_LEADING_ZERO_COUNT &&
      sourceValueRegQ == 32'h0000_0000 |=> destQ == 32'h0000_0020 && $stable(flagsQ))
    else $error("leading zero count of zero wrong");
  a_cmp_no_dest: assert property (execStrobe && op == OP_COMPARE |=> $stable(destQ))
    else $error("compare wrote destination");
  a_cmn_carry: assert property (execStrobe && op == OP_COMPARE_NEGATIVE |=>
      flagsQ[`SMCR_FLAG_C] == ({1'b0, $past(firstOperandRegQ)} + {1'b0, $past(shOut)}) >> 32)
    else $error("compare negative carry wrong");
  a_source_kept: assert property (execStrobe |=> $stable(sourceValueRegQ))
    else $error("source changed by execution");
  a_top_half: assert property (execStrobe && op == OP_LOAD_TOP_HALF |=>
      destQ == {$past(wideImmediateQ), $past(destQ[15:0])} && $stable(flagsQ))
    else $error("load top half wrong");
  a_word_swap: assert property (execStrobe && op == OP_BYTE_SWAP_WORD |=>
      destQ == {<<8{$past(sourceValueRegQ)}} && $stable(flagsQ))
    else $error("word byte swap wrong");
  a_mirror_bits: assert property (execStrobe && op == OP_BIT_MIRROR |=>
      destQ == {<<{$past(sourceValueRegQ)}})
    else $error("bit mirror wrong");
  a_carry_extend: assert property (execStrobe && op == OP_ROTATE_THROUGH_CARRY &&
      setFlags |=> destQ == {$past(flagsQ[`SMCR_FLAG_C]), $past(sourceValueRegQ[31:1])}
      && flagsQ[`SMCR_FLAG_C] == $past(sourceValueRegQ[0]))
    else $error("rotate through carry wrong");
  a_zero_shift_c: assert property (execStrobe && op == OP_SHIFT_LEFT_LOGICAL &&
      amount == 8'h00 |=> $stable(flagsQ[`SMCR_FLAG_C]) && destQ == $past(sourceValueRegQ))
    else $error("zero shift changed carry");
  a_branch_even: assert property (execStrobe && branchD |=>
      branchStrobe && !branchTarget[0] ##1 !branchStrobe)
    else $error("branch target odd or strobe long");
  a_shamt_byte: assert property (execStrobe && op == OP_SHIFT_RIGHT_LOGICAL &&
      !ctrlQ[`SMCR_CTL_USEIMM] && shiftAmountRegQ[7:5] != 3'h0 |=> destQ == 32'h0)
    else $error("register shift byte ignored");

  c_compare: cover property (execStrobe && op == OP_COMPARE);
  c_branch: cover property (execStrobe && branchD);
  c_long_shift: cover property (execStrobe && op == OP_SHIFT_RIGHT_ARITHMETIC && amount > 8'h20);

endmodule // smcr_alu

/* dv/smcr_host_model.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------
// register-file side: apb master
// ----------------------------------------------------------------
module smcr_host_model
(
  input  wire logic        clk_sys,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [7:0]  paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
  end

  // released address and data are scrambled so stale values never match
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // no cycle limit here: a hang is ended by the bench timeout
    do
    begin
      @(posedge clk_sys);
    end
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask
endmodule // smcr_host_model

/* dv/shift_move_compare_reverse_alu_test.sv */
`timescale 1ns/10ps
`include "smcr_map.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module shift_move_compare_reverse_alu_test;
  logic        clk_sys;
  logic        sys_rst;
  logic        clkEn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        pready;
  logic        pslverr;
  logic        branchStrobe;
  logic        execDone;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] destValue;
  logic [31:0] branchTarget;
  logic [3:0]  flagsNzcv;
  logic [31:0] rdVal;
  logic        rdErr;
  int          failures;
  int          checks_done;
  int          cycles;

  smcr_alu u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .clkEn(clkEn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .destValue(destValue), .flagsNzcv(flagsNzcv),
    .branchTarget(branchTarget), .branchStrobe(branchStrobe), .execDone(execDone));

  smcr_host_model u_host (.clk_sys(clk_sys), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    u_host.xfer(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a);
    u_host.xfer(1'b0, a, 32'h0000_0000, rdVal, rdErr);
  endtask

  // ----------------------------------------------------------------
  // one operation: preset, execute, read back result and flags
  // ----------------------------------------------------------------
  task automatic ex(input logic [31:0] ctl, input logic [31:0] fst, input logic [31:0] src,
                    input logic [31:0] sh, input logic [3:0] fin, input logic [31:0] eD,
                    input logic [3:0] eF);
    wr(`SMCR_ADDR_DEST, 32'h5555_aaaa);
    wr(`SMCR_ADDR_FIRST, fst);
    wr(`SMCR_ADDR_SOURCE, src);
    wr(`SMCR_ADDR_SHAMT, sh);
    wr(`SMCR_ADDR_FLAGS, {28'h0000_000, fin});
    wr(`SMCR_ADDR_CTRL, ctl);
    wr(`SMCR_ADDR_EXEC, 32'h0000_0001);
    @(negedge clk_sys);
    `CHK({execDone, branchStrobe}, {1'b1, ctl[`SMCR_CTL_TOPC] && ctl[3:0] == 4'h8})
    rd(`SMCR_ADDR_DEST);
    `CHK(rdVal, eD)
    rd(`SMCR_ADDR_FLAGS);
    `CHK(rdVal, {28'h0000_000, eF})
    `CHK(destValue, eD)
  endtask

  initial
  begin
    clkEn    = 1'b1;
    sys_rst  = 1'b1;
    failures = 0;
    checks_done = 0;
    cycles   = 0;
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(negedge clk_sys);
    `CHK({destValue, flagsNzcv, branchTarget, execDone}, 69'h0)
    wr(`SMCR_ADDR_WIDE, 32'h0000_f123);
    ex(32'h80, 0, 32'h1000_0001, 32'h104, 4'h1, 32'h0000_0010, 4'h3);
    ex(32'h80, 0, 32'h8000_0000, 32'h100, 4'h2, 32'h8000_0000, 4'ha);
    ex(32'h0020_00c1, 0, 32'h8000_0000, 0, 4'h0, 32'h0, 4'h6);
    ex(32'h0001_00c2, 0, 32'h8000_0003, 0, 4'h0, 32'hc000_0001, 4'ha);
    ex(32'h01, 0, 32'hffff_ffff, 32'h140, 4'h5, 32'h0, 4'h5);
    ex(32'h82, 0, 32'h8000_0000, 32'h40, 4'h0, 32'hffff_ffff, 4'ha);
    ex(32'h001f_00c0, 0, 32'h0000_0003, 0, 4'h0, 32'h8000_0000, 4'ha);
    ex(32'h83, 0, 32'h1234_5678, 32'h8, 4'h5, 32'h7812_3456, 4'h1);
    ex(32'h84, 0, 32'h0000_0003, 0, 4'h2, 32'h8000_0001, 4'ha);
    ex(32'h84, 0, 32'h0000_0002, 0, 4'hf, 32'h8000_0001, 4'h9);
    rd(`SMCR_ADDR_SOURCE);
    `CHK(rdVal, 32'h0000_0002)
    ex(32'h85, 0, 32'h0, 0, 4'h5, 32'h0000_0020, 4'h5);
    ex(32'h85, 0, 32'h8000_0000, 0, 4'ha, 32'h0, 4'ha);
    ex(32'h85, 0, 32'h0001_0000, 0, 4'h0, 32'h0000_000f, 4'h0);
    ex(32'h06, 32'h5, 32'h5, 0, 4'hf, 32'h5555_aaaa, 4'h6);
    ex(32'h06, 32'h8000_0000, 32'h1, 0, 4'h0, 32'h5555_aaaa, 4'h3);
    ex(32'h07, 32'hffff_ffff, 32'h1, 0, 4'h0, 32'h5555_aaaa, 4'h6);
    ex(32'h07, 32'h7fff_ffff, 32'h1, 0, 4'h0, 32'h5555_aaaa, 4'h9);
    ex(32'h98, 0, 32'h0000_0001, 32'h1, 4'h1, 32'h0, 4'h7);
    ex(32'h08, 0, 32'hdead_beef, 0, 4'h6, 32'hdead_beef, 4'h6);
    ex(32'h89, 0, 32'h0000_000f, 0, 4'h0, 32'hffff_fff0, 4'h8);
    ex(32'h0a, 0, 0, 0, 4'h9, 32'h0000_f123, 4'h9);
    ex(32'h0b, 0, 0, 0, 4'h6, 32'hf123_aaaa, 4'h6);
    ex(32'h0c, 0, 32'h1122_3344, 0, 4'hf, 32'h4433_2211, 4'hf);
    ex(32'h0d, 0, 32'h1122_3344, 0, 4'h5, 32'h2211_4433, 4'h5);
    ex(32'h0e, 0, 32'h1122_3480, 0, 4'ha, 32'hffff_8034, 4'ha);
    ex(32'h0f, 0, 32'h1234_5678, 0, 4'h3, 32'h1e6a_2c48, 4'h3);
    ex(32'h108, 0, 32'h0000_1235, 0, 4'h6, 32'h5555_aaaa, 4'h6);
    rd(`SMCR_ADDR_BRANCH);
    `CHK(rdVal, 32'h0000_1234)
    `CHK(branchTarget, 32'h0000_1234)
    rd(`SMCR_ADDR_STATUS);
    `CHK(rdVal, 32'h0000_0002)
    // frozen clock enable: no answer until it returns
    clkEn <= 1'b0;
    fork
      rd(`SMCR_ADDR_DEST);
      begin
        repeat (6) @(posedge clk_sys);
        `CHK(pready, 1'b0)
        clkEn <= 1'b1;
      end
    join
    `CHK(rdVal, 32'h5555_aaaa)
    rd(8'h40);
    `CHK({rdErr, rdVal}, {1'b1, 32'h0})
    give_verdict();
  end
endmodule // shift_move_compare_reverse_alu_test
